// ==== pmr_data_port.sv ====
// MII/RMII data port, interrupt register and interface-mode straps of the PHY
// Summary of operation
// - Upper byte enables interrupt conditions
// - Lower byte holds per-condition status flags
// - Reading interrupt register clears status flags
// - Control bit nine selects interrupt polarity
// - Straps 000 select MII mode by default
// - Device sources transmit clock, samples TX
// - Transmit data accepted only while enabled
// - Slow receive clock 2.5MHz from reference timebase
// - Fast receive clock 25MHz, still from timebase on linkdown
// - Slow data valid rises at SFD nibble
// - Fast data valid spans preamble to end
// - One nibble per receive clock when valid
// - Receive error flagged during erroneous frame
// - Slow carrier: preamble sets, end marker clears
// - Fast carrier: J/K sets, T/R or idle clears
// - Half-duplex collision asynchronous when transmit meets receive
// - Straps 001 select RMII, reference clock out
// - RMII uses two-bit paths on reference clock
// - MII uses separate four-bit paths
// - RMII data paths all timed by reference clock
// - Fast RMII carrier rises asynchronously on zeros
// - RMII presents two bits per clock at speed_100, per ten clocks otherwise
`timescale 1ns/1ps
module pmr_data_port (
	input  wire logic                 ref_clk,
	input  wire logic                 reset_n,
	input  wire logic [2:0]           strap_config,
	input  wire logic                 speed_100,
	input  wire logic                 duplex_full,
	input  wire logic                 link_up,
	input  wire logic [4:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [15:0]          reg_rdata,
	input  wire logic [7:0]           int_event,
	output logic                      irq_out,
	output logic                      txc,
	output logic                      rxc,
	output logic                      rmii_ref_out,
	input  wire logic                 tx_en,
	input  wire logic [3:0]           txd,
	output pmr_pkg::pmr_tx_nib_t      tx_line,
	input  wire pmr_pkg::pmr_rx_nib_t rx_line,
	input  wire pmr_pkg::pmr_carrier_t carrier,
	output logic                      rx_dv,
	output logic [3:0]                rxd,
	output logic                      rx_er,
	output logic                      crs,
	output logic                      crs_dv,
	output logic                      col,
	output logic                      rmii_mode
);
	logic [2:0]            strap_s1, strap_s2, strap_s3;
	logic                  strap_taken;
	logic [2:0]            strap_fill;
	logic [7:0]            int_en, int_flags;
	logic [15:0]           ctrl;
	logic                  irq_pol_high;
	logic [3:0]            div_cnt;
	logic                  phase, tick, tx_sample, rx_load, rx_second;
	logic [3:0]            tx_lo;
	logic                  tx_lo_valid;
	pmr_pkg::pmr_rx_nib_t  rx_hold;
	logic                  rx_full;
	logic [3:0]            rx_cur;
	pmr_pkg::pmr_rx_state_t rx_state;
	logic                  present, rx_dv_q, crs_q;

	function automatic logic [3:0] half_div(input logic fast);
		half_div = fast ? 4'(pmr_pkg::HALF_DIV_100) : 4'(pmr_pkg::HALF_DIV_10);
	endfunction

	// Straps: three-stage sync, caught once the chain holds only pin samples
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_s1    <= 3'h0;
			strap_s2    <= 3'h0;
			strap_s3    <= 3'h0;
			strap_fill  <= 3'h0;
			strap_taken <= 1'b0;
			rmii_mode   <= 1'b0;
		end else begin
			strap_s1   <= strap_config;
			strap_s2   <= strap_s1;
			strap_s3   <= strap_s2;
			strap_fill <= {strap_fill[1:0], 1'b1};
			if (!strap_taken && strap_fill[2] && strap_s2 == strap_s3) begin
				strap_taken <= 1'b1;
				rmii_mode   <= (strap_s3 == pmr_pkg::CFG_RMII);
			end
		end
	end

	// RMII reference clock forwarded to the MAC
	assign rmii_ref_out = rmii_mode & ref_clk;

	// Registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			int_en    <= pmr_pkg::INT_EN_RESET;
			int_flags <= pmr_pkg::INT_FLAG_RESET;
			ctrl      <= pmr_pkg::CTRL_RESET;
			reg_rdata <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == pmr_pkg::REG_INT_ADDR) begin
				int_en <= reg_wdata[pmr_pkg::INT_EN_MSB:pmr_pkg::INT_EN_LSB];
			end
			if (reg_wr && reg_addr == pmr_pkg::REG_CTRL_ADDR) begin
				ctrl <= reg_wdata;
			end
			if (reg_rd && reg_addr == pmr_pkg::REG_INT_ADDR) begin
				int_flags <= int_event;
			end else begin
				int_flags <= int_flags | int_event;
			end
			if (reg_rd) begin
				case (reg_addr)
					pmr_pkg::REG_INT_ADDR:  reg_rdata <= {int_en, int_flags};
					pmr_pkg::REG_CTRL_ADDR: reg_rdata <= ctrl;
					default:                reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	assign irq_pol_high = ctrl[pmr_pkg::CTRL_IRQ_POL];

	// Interrupt pin, held while any enabled flag stands
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_out <= 1'b1;
		end else begin
			irq_out <= (|(int_flags & int_en)) ~^ irq_pol_high;
		end
	end

	// Shared timebase: tick per half MII clock period, one tick per RMII di-bit
	assign tick = (div_cnt >= half_div(speed_100) - 4'h1);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= 4'h0;
			phase   <= 1'b0;
		end else if (tick) begin
			div_cnt <= 4'h0;
			phase   <= ~phase;
		end else begin
			div_cnt <= div_cnt + 4'h1;
		end
	end

	// Receive clock runs from the local timebase; line timing arrives aligned to it
	assign txc = phase & ~rmii_mode;
	assign rxc = phase & ~rmii_mode;

	// MII samples on the rising edge of txc; RMII samples every di-bit tick
	assign tx_sample = tick && (rmii_mode || !phase);
	assign rx_load   = tick && (rmii_mode ? !phase : phase);
	assign rx_second = tick && rmii_mode && phase;

	// Transmit path
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_line     <= '0;
			tx_lo       <= 4'h0;
			tx_lo_valid <= 1'b0;
		end else begin
			tx_line.valid <= 1'b0;
			if (tx_sample && tx_en) begin
				if (!rmii_mode) begin
					tx_line.valid <= 1'b1;
					tx_line.data  <= txd;
				end else if (!tx_lo_valid) begin
					// Pairing starts at the first di-bit after tx_en rises
					tx_lo       <= {2'b00, txd[1:0]};
					tx_lo_valid <= 1'b1;
				end else begin
					tx_line.valid <= tx_lo_valid;
					tx_line.data  <= {txd[1:0], tx_lo[1:0]};
					tx_lo_valid   <= 1'b0;
				end
			end else if (tx_sample) begin
				tx_lo_valid <= 1'b0;
			end
		end
	end

	// Receive holding register, refilled by the line; a new nibble wins over the take
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_hold <= '0;
			rx_full <= 1'b0;
		end else if (rx_line.valid) begin
			rx_hold <= rx_line;
			rx_full <= 1'b1;
		end else if (rx_load) begin
			rx_full <= 1'b0;
		end
	end

	assign present = rx_full && (rx_state == pmr_pkg::PMR_RX_DATA || speed_100
		|| rx_hold.sfd);

	// Receive framing
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_state <= pmr_pkg::PMR_RX_IDLE;
		end else if (!link_up) begin
			rx_state <= pmr_pkg::PMR_RX_IDLE;
		end else if (rx_load) begin
			case (rx_state)
				pmr_pkg::PMR_RX_IDLE, pmr_pkg::PMR_RX_PRE: begin
					if (present && !rx_hold.last) begin
						rx_state <= pmr_pkg::PMR_RX_DATA;
					end else if (rx_full && !present) begin
						rx_state <= pmr_pkg::PMR_RX_PRE;
					end
				end
				pmr_pkg::PMR_RX_DATA: begin
					if (!rx_full || rx_hold.last) begin
						rx_state <= pmr_pkg::PMR_RX_IDLE;
					end
				end
				default: rx_state <= pmr_pkg::PMR_RX_IDLE;
			endcase
		end
	end

	// Receive outputs change only at nibble or di-bit boundaries
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_dv_q <= 1'b0;
			rxd     <= 4'h0;
			rx_er   <= 1'b0;
			rx_cur  <= 4'h0;
		end else if (rx_load) begin
			rx_dv_q <= present;
			rx_er   <= present && rx_hold.err;
			rx_cur  <= present ? rx_hold.data : 4'h0;
			if (!present) begin
				rxd <= 4'h0;
			end else if (rmii_mode) begin
				rxd <= {2'b00, rx_hold.data[1:0]};
			end else begin
				rxd <= rx_hold.data;
			end
		end else if (rx_second) begin
			rxd <= {2'b00, rx_cur[3:2]};
		end
	end

	assign rx_dv = rx_dv_q & ~rmii_mode;

	// Carrier sense; set wins over clear
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			crs_q <= 1'b0;
		end else if (!link_up) begin
			crs_q <= 1'b0;
		end else if (speed_100 ? carrier.jk : carrier.preamble_ok) begin
			crs_q <= 1'b1;
		end else if (speed_100 ? (carrier.tr || carrier.idle_sym) : carrier.eof) begin
			crs_q <= 1'b0;
		end
	end

	assign crs    = crs_q & ~rmii_mode;
	assign crs_dv = rmii_mode & (crs_q | rx_dv_q
		| (speed_100 & link_up & carrier.two_zeros));
	assign col    = ~duplex_full & tx_en & (crs_q | rx_dv_q);

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_irq_cause;
		(|(int_event & int_en)) ##1 (!reg_wr);
	endsequence

	sequence s_slow_rise;
		$rose(txc) && !speed_100 && !rmii_mode;
	endsequence

	AST_IRQ_ASSERT: assert property (s_irq_cause |=> irq_out == irq_pol_high)
		else $error("interrupt did not assert after enabled event");
	AST_FLAG_CLEAR: assert property (reg_rd && reg_addr == pmr_pkg::REG_INT_ADDR
		&& int_event == 8'h00 |=> int_flags == 8'h00)
		else $error("status flags not cleared by read");
	AST_FLAG_STICKY: assert property (!(reg_rd && reg_addr == pmr_pkg::REG_INT_ADDR)
		|=> (int_flags & $past(int_flags)) == $past(int_flags))
		else $error("status flag lost without a read");
	AST_IRQ_IDLE: assert property ((int_flags & int_en) == 8'h00 && $stable(ctrl)
		|=> irq_out == !$past(irq_pol_high))
		else $error("interrupt active with no enabled flag");
	AST_TX_IGNORE: assert property (tx_sample && !tx_en |=> !tx_line.valid)
		else $error("transmit nibble taken while enable low");
	AST_TX_ACCEPT: assert property (!rmii_mode && tx_sample && tx_en
		|=> tx_line.valid && tx_line.data == $past(txd))
		else $error("MII transmit nibble not accepted");
	AST_CLK_100: assert property ((!rmii_mode && speed_100)[*2]
		|-> txc != $past(txc))
		else $error("fast MII clock not at half reference rate");
	AST_CLK_10: assert property (s_slow_rise ##1 (!speed_100)[*8] |=> txc)
		else $error("slow MII clock high phase too short");
	AST_RXD_IDLE: assert property (!rx_dv_q |-> rxd == 4'h0)
		else $error("receive data not idle while invalid");
	AST_CRS_JK: assert property (link_up && speed_100 && carrier.jk |=> crs_q)
		else $error("carrier not raised on start-of-stream");
	AST_STRAP_HOLD: assert property (strap_taken |=> strap_taken && $stable(rmii_mode))
		else $error("interface mode changed after strap capture");

endmodule // pmr_data_port

// ==== pmr_mac_model.sv ====
// Behavioural MAC transmit side that feeds nibbles into the data port
`timescale 1ns/1ps
module pmr_mac_model (
	input  wire logic       ref_clk,
	input  wire logic       txc,
	input  wire logic       rmii,
	input  wire logic       junk,
	output logic            tx_en,
	output logic [3:0]      txd
);
	logic       txc_q;
	logic       hi;
	logic [3:0] nib_q[$];

	initial begin
		tx_en = 1'h0;
		txd = 4'h0;
		txc_q = 1'h0;
		hi = 1'h0;
	end

	task automatic send(input logic [3:0] n);
		nib_q.push_back(n);
	endtask

	// Launch just after a transmit clock rise so each nibble stands a whole period
	always @(negedge ref_clk) begin
		txc_q <= txc;
		if (rmii) begin
			// One di-bit per reference clock, low half of each nibble first
			tx_en <= nib_q.size() != 0;
			if (nib_q.size() == 0)
				txd <= {2'b00, {2{junk}}};
			else
				txd <= {2'b00, hi ? nib_q[0][3:2] : nib_q[0][1:0]};
			hi <= nib_q.size() != 0 && !hi;
			if (hi)
				void'(nib_q.pop_front());
		end else if (txc && !txc_q) begin
			tx_en <= nib_q.size() != 0;
			// Idle junk only when a scenario asks for it; unused upper bits grounded in RMII
			txd <= nib_q.size() != 0 ? nib_q.pop_front() : {{2{junk & ~rmii}}, {2{junk}}};
		end
	end
endmodule // pmr_mac_model

// ==== pmr_pkg.sv ====
// Constants, field layouts and carrier types for the MAC-facing data port
package pmr_pkg;

	// Register addresses on the management access port
	localparam logic [4:0]  REG_INT_ADDR   = 5'h1B;
	localparam logic [4:0]  REG_CTRL_ADDR  = 5'h1F;

	// Interrupt register fields and control-register interrupt polarity bit
	localparam int          INT_EN_MSB     = 15;
	localparam int          INT_EN_LSB     = 8;
	localparam int          INT_FLAG_MSB   = 7;
	localparam int          INT_FLAG_LSB   = 0;
	localparam int          CTRL_IRQ_POL   = 9;

	// Reset values
	localparam logic [7:0]  INT_EN_RESET   = 8'h00;
	localparam logic [7:0]  INT_FLAG_RESET = 8'h00;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;

	// Interface-select strap codes
	localparam logic [2:0]  CFG_MII        = 3'h0;
	localparam logic [2:0]  CFG_RMII       = 3'h1;

	// Timing: ref_clk rate and MII clock rates, half periods in ref_clk cycles
	localparam int          REF_CLK_HZ     = 50_000_000;
	localparam int          MII_CLK_10_HZ  = 2_500_000;
	localparam int          MII_CLK_100_HZ = 25_000_000;
	localparam int          HALF_DIV_10    = REF_CLK_HZ / (2 * MII_CLK_10_HZ);
	localparam int          HALF_DIV_100   = REF_CLK_HZ / (2 * MII_CLK_100_HZ);

	// Receive framing states
	typedef enum logic [2:0] {
		PMR_RX_IDLE = 3'b001,
		PMR_RX_PRE  = 3'b010,
		PMR_RX_DATA = 3'b100
	} pmr_rx_state_t;

	// Decoded nibble from the line receiver, valid is a one-cycle strobe
	typedef struct packed {
		logic       valid;
		logic [3:0] data;
		logic       sfd;
		logic       last;
		logic       err;
	} pmr_rx_nib_t;

	// Carrier events from the line receiver, each a one-cycle strobe
	typedef struct packed {
		logic preamble_ok;
		logic eof;
		logic jk;
		logic tr;
		logic idle_sym;
		logic two_zeros;
	} pmr_carrier_t;

	// Nibble handed to the line transmitter
	typedef struct packed {
		logic       valid;
		logic [3:0] data;
	} pmr_tx_nib_t;

endpackage

// ==== test_phy_mii_rmii_data_port.sv ====
// Self-checking bench for the MII/RMII data port and its interrupt register
`timescale 1ns/1ps
module test_phy_mii_rmii_data_port;
	logic                  ref_clk = 1'h0;
	logic                  reset_n, speed_100, duplex_full, link_up, reg_wr, reg_rd;
	logic                  irq_out, txc, rxc, rmii_ref_out, tx_en, rx_dv, rx_er, crs;
	logic                  crs_dv, col, rmii_mode, junk, carr_on, rxc_q, rx_half, rx_take;
	logic [1:0]            rx_lo;
	logic [2:0]            strap_config;
	logic [4:0]            reg_addr;
	logic [15:0]           reg_wdata, reg_rdata;
	logic [7:0]            int_event;
	logic [3:0]            txd, rxd;
	logic [31:0]           seed = 32'h0000EB65;
	pmr_pkg::pmr_tx_nib_t  tx_line;
	pmr_pkg::pmr_rx_nib_t  rx_line;
	pmr_pkg::pmr_carrier_t carrier;
	logic [3:0]            txq[$];
	logic [4:0]            rxq[$];
	int                    err_total = 0;
	int                    num_checks = 0;

	always #10 ref_clk = ~ref_clk;

	pmr_data_port dut_u (.ref_clk, .reset_n, .strap_config, .speed_100, .duplex_full, .link_up,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .int_event, .irq_out, .txc, .rxc,
		.rmii_ref_out, .tx_en, .txd, .tx_line, .rx_line, .carrier, .rx_dv, .rxd, .rx_er, .crs,
		.crs_dv, .col, .rmii_mode);
	pmr_mac_model mac_u (.ref_clk, .txc, .rmii(rmii_mode), .junk, .tx_en, .txd);

	function automatic logic [3:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[3:0];
	endfunction

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic reset(input logic [2:0] st);
		strap_config <= st;
		reset_n <= 1'h0;
		repeat (20) @(negedge ref_clk);
		reset_n <= 1'h1;
		repeat (8) @(negedge ref_clk);
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(negedge ref_clk) reg_wr <= 1'h0;
	endtask

	task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(negedge ref_clk) reg_rd <= 1'h0;
		@(negedge ref_clk) check("reg_rdata", reg_rdata, exp);
	endtask

	task automatic ev(input logic [7:0] m, input logic exp);
		int_event <= m;
		@(negedge ref_clk) int_event <= 8'h00;
		repeat (3) @(negedge ref_clk);
		check("irq_out", irq_out, exp);
	endtask

	task automatic pulse_carrier(input logic [5:0] m, input logic exp);
		carrier <= m;
		@(negedge ref_clk) carrier <= '0;
		@(negedge ref_clk) check("crs", crs, exp);
	endtask

	task automatic txc_period(input int cyc);
		time t0;
		@(posedge txc);
		t0 = $time;
		@(posedge txc);
		check("txc_period", 16'(($time - t0) / 20), 16'(cyc));
		@(negedge ref_clk);
	endtask

	task automatic tx_frame(input int per);
		logic [3:0] d;
		for (int i = 0; i < 8; i++) begin
			d = rnd();
			txq.push_back(d);
			mac_u.send(d);
		end
		for (int k = 0; k < 30 * per && txq.size() != 0; k++)
			@(negedge ref_clk);
		repeat (3 * per) @(negedge ref_clk);
		check("tx_left", 16'(txq.size()), 16'h0000);
	endtask

	// Three preamble nibbles, then the delimiter nibble and five data nibbles
	task automatic rx_frame(input int per);
		logic [3:0] d;
		for (int i = 0; i < 9; i++) begin
			d = (i < 3) ? 4'h5 : rnd();
			if (speed_100 || i >= 3)
				rxq.push_back({i == 4, d});
			rx_line <= {1'h1, d, i == 3, i == 8, i == 4};
			@(negedge ref_clk) rx_line <= '0;
			repeat (per - 1) @(negedge ref_clk);
		end
		repeat (4 * per) @(negedge ref_clk);
		check("rx_left", 16'(rxq.size()), 16'h0000);
	endtask

	always @(negedge ref_clk) begin
		if (tx_line.valid)
			check("tx_line", tx_line.data, txq.size() != 0 ? txq.pop_front() : 16'hFFFF);
		if (rxc && !rxc_q && rx_dv)
			check("rx_nibble", {rx_er, rxd}, rxq.size() != 0 ? rxq.pop_front() : 16'hFFFF);
		if (tx_en && !rx_dv)
			check("col", col, carr_on & ~duplex_full);
		// RMII: pair di-bits from the rise of crs_dv; the carrier-only pulse carries no data
		rx_take = rmii_mode && crs_dv && !carrier.two_zeros;
		if (rx_take && rx_half)
			check("rx_dibits", {rx_er, rxd[1:0], rx_lo},
				rxq.size() != 0 ? rxq.pop_front() : 16'hFFFF);
		else if (rx_take)
			rx_lo = rxd[1:0];
		rx_half = rx_take && !rx_half;
		rxc_q = rxc;
	end

	initial begin
		reset_n = 1'h0;
		strap_config = 3'h0;
		speed_100 = 1'h1;
		duplex_full = 1'h0;
		link_up = 1'h1;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		int_event = 8'h00;
		rx_line = '0;
		carrier = '0;
		junk = 1'h0;
		carr_on = 1'h0;
		rxc_q = 1'h0;
		rx_half = 1'h0;
		rx_lo = 2'h0;
		reset(3'h0);
		check("rmii_mode", rmii_mode, 1'h0);
		rd_reg(5'h1B, 16'h0000);
		rd_reg(5'h03, 16'h0000);
		wr_reg(5'h1B, 16'hFFAA);
		rd_reg(5'h1B, 16'hFF00);
		wr_reg(5'h1B, 16'h0100);
		ev(8'h02, 1'h1);
		ev(8'h01, 1'h0);
		rd_reg(5'h1B, 16'h0103);
		ev(8'h00, 1'h1);
		rd_reg(5'h1B, 16'h0100);
		wr_reg(5'h1F, 16'h0200);
		ev(8'h00, 1'h0);
		ev(8'h01, 1'h1);
		rd_reg(5'h1B, 16'h0101);
		wr_reg(5'h1F, 16'h0000);
		ev(8'h00, 1'h1);
		$display("test registers done");
		for (int s = 1; s >= 0; s--) begin
			speed_100 <= s[0];
			duplex_full <= ~s[0];
			junk <= ~s[0];
			repeat (40) @(negedge ref_clk);
			txc_period(s ? 2 : 20);
			pulse_carrier(s ? 6'h08 : 6'h20, 1'h1);
			carr_on = 1'h1;
			tx_frame(s ? 2 : 20);
			pulse_carrier(s ? 6'h04 : 6'h10, 1'h0);
			carr_on = 1'h0;
			rx_frame(s ? 2 : 20);
			$display("test speed %0d done", s);
		end
		speed_100 <= 1'h1;
		pulse_carrier(6'h08, 1'h1);
		pulse_carrier(6'h02, 1'h0);
		reset(3'h1);
		check("rmii_mode", rmii_mode, 1'h1);
		check("txc", txc, 1'h0);
		check("rx_dv", rx_dv, 1'h0);
		@(posedge ref_clk) #1 check("rmii_ref_out", rmii_ref_out, 1'h1);
		@(negedge ref_clk) carrier <= 6'h01;
		#1 check("rmii_ref_out", rmii_ref_out, 1'h0);
		check("crs_dv", crs_dv, 1'h1);
		@(negedge ref_clk) carrier <= '0;
		tx_frame(1);
		rx_frame(2);
		$display("test rmii done");
		results();
	end

	// The whole run needs under a thousand cycles; this bound only cuts a hang short
	initial begin
		#400000;
		err_total++;
		results();
	end
endmodule // test_phy_mii_rmii_data_port
